// ===== i2c_ten_bit_pkg.sv
package i2c_ten_bit_pkg;

    // register indices on the plain register port
    localparam logic [2:0] BUFFER_OFS = 3'h0;
    localparam logic [2:0] STATUS_OFS = 3'h1;
    localparam logic [2:0] CTRL_ONE_OFS = 3'h2;
    localparam logic [2:0] CTRL_TWO_OFS = 3'h3;
    localparam logic [2:0] CTRL_THREE_OFS = 3'h4;
    localparam logic [2:0] MASK_OFS = 3'h5;
    localparam logic [2:0] ADDRESS_OFS = 3'h6;
    localparam logic [2:0] FLAG_OFS = 3'h7;

    // serial_status field positions
    localparam int ST_BF = 0;
    localparam int ST_UA = 1;
    localparam int ST_START = 3;
    localparam int ST_STOP = 4;
    localparam int ST_DATA = 5;

    // serial_control_one field positions
    localparam int C1_OVERFLOW = 6;
    localparam int C1_ENABLE = 5;
    localparam int C1_CLOCK_RELEASE = 4;

    // serial_control_two / serial_control_three field positions
    localparam int C2_STRETCH_ENABLE = 0;
    localparam int C3_START_IRQ_EN = 5;
    localparam int C3_ADDRESS_HOLD = 1;
    localparam int C3_DATA_HOLD = 0;

    // values after reset
    localparam logic [7:0] CTRL_ONE_RST = 8'h10;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'hFF;
    localparam logic [7:0] ADDRESS_RST = 8'h00;
    localparam logic [7:0] BUFFER_RST = 8'h00;

    // bit counts within one byte cycle on the bus
    localparam logic [3:0] LAST_DATA_BIT = 4'h8;
    localparam logic [3:0] ACK_BIT = 4'h9;

    // register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // receive sequencer states
    typedef enum logic [4:0] {
        IDLE = 5'b00001,
        ADDR_HI = 5'b00010,
        ADDR_LO = 5'b00100,
        DATA = 5'b01000,
        IGNORE = 5'b10000
    } rx_state_t;

endpackage : i2c_ten_bit_pkg

// ===== i2c_slave_ten_bit_addressing.sv
// Operation
// [RQ1] start sets start bit, optional flag
// [RQ2] matching high address: update, ack, flag
// [RQ3] buffer read clears buffer full
// [RQ4] hold clock until address rewritten
// [RQ5] software writes address only after ack
// [RQ6] matching low address: update, ack, flag, buffer
// [RQ7] low miss: flag, update; no full
// [RQ8] ack on ninth pulse, then flag
// [RQ9] stretch enabled: clear release, hold clock
// [RQ10] setting release frees the clock
// [RQ11] hold modes behave as seven-bit
// [RQ12] byte cycle repeats until stop
// [RQ13] master sends start, addresses, data, stop
// [RQ14] high byte carries ten-bit prefix
//
// Implementation choices: the register offsets and the address-and-strobe port.
module i2c_slave_ten_bit_addressing
    import i2c_ten_bit_pkg::*;
#(
    parameter int BYTE_W = 8
) (
    // system clock, reset and enable
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // serial clock used as the link-side clock
    input wire logic scl_clk_i,
    // two-way bus pins
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // register port
    input wire reg_req_t req_i,
    output logic [7:0] rdata_o,
    // port interrupt flag level
    output logic port_interrupt_flag_o
);

    // the byte path is built for eight-bit bytes only
    if (BYTE_W != 8) begin : g_width_check
        $error("BYTE_W must be 8");
    end

    // link domain shift register, sampled on each serial clock rise
    logic [7:0] link_shift_reg;

    // synchronisers and their history stage
    logic [2:0] scl_sync_reg;
    logic [2:0] sda_sync_reg;

    // sequencer and bit counting
    rx_state_t state_reg;
    logic [3:0] bit_cnt_reg;

    // registers seen by software
    logic [7:0] serial_buffer_reg;
    logic [7:0] serial_control_one_reg;
    logic [7:0] serial_control_two_reg;
    logic [7:0] serial_control_three_reg;
    logic [7:0] address_mask_reg;
    logic [7:0] slave_address_reg;
    logic [7:0] rdata_reg;

    // status bits
    logic buffer_full_reg;
    logic update_address_reg;
    logic start_seen_reg;
    logic stop_seen_reg;
    logic data_last_reg;
    logic port_interrupt_flag_reg;

    // per-byte bookkeeping between the eighth rise and the ack
    logic ack_pend_reg;
    logic event_pend_reg;
    logic addr_kind_reg;
    logic ua_kind_reg;
    logic ua_hold_reg;

    // pin drivers
    logic scl_oe_reg;
    logic sda_oe_reg;

    // decoded bus events
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic byte_done;
    logic data_fall;
    logic ack_fall;
    logic active;

    // address compare and byte events
    logic [7:0] rx_byte;
    logic hi_match;
    logic lo_match;
    logic addr_hit;
    logic lo_miss;
    logic data_rx;
    logic store_byte;

    // software accesses
    logic wr_buffer;
    logic rd_buffer;
    logic wr_ctrl_one;
    logic wr_address;
    logic wr_flag;

    // link side: shift in the data line on every serial clock rise
    always_ff @(posedge scl_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            link_shift_reg <= 8'h00;
        end else begin
            link_shift_reg <= {link_shift_reg[6:0], sda_i};
        end
    end

    // two-flop synchronisers plus one history stage for edge detection
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
        end else if (ce_i) begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
        end
    end

    // edge and condition decode from synchronised stages only
    assign scl_rise = scl_sync_reg[1] & ~scl_sync_reg[2];
    assign scl_fall = ~scl_sync_reg[1] & scl_sync_reg[2];
    assign start_det = scl_sync_reg[1] & scl_sync_reg[2] & ~sda_sync_reg[1] & sda_sync_reg[2];
    assign stop_det = scl_sync_reg[1] & scl_sync_reg[2] & sda_sync_reg[1] & ~sda_sync_reg[2];
    assign active = state_reg inside {ADDR_HI, ADDR_LO, DATA};
    assign byte_done = active & scl_rise & (bit_cnt_reg == LAST_DATA_BIT - 4'h1);
    assign data_fall = scl_fall & (bit_cnt_reg == LAST_DATA_BIT);
    assign ack_fall = scl_fall & (bit_cnt_reg == ACK_BIT);

    // the link register is still for a full serial period after the
    // eighth rise, so reading it on the synchronised rise is safe
    assign rx_byte = link_shift_reg;

    // high byte: stored address bits with the write direction [RQ14]
    assign hi_match = (rx_byte[7:1] == slave_address_reg[7:1]) & ~rx_byte[0];
    // low byte: masked compare against the stored address
    assign lo_match = ((rx_byte ^ slave_address_reg) & address_mask_reg) == 8'h00;
    assign addr_hit = byte_done & (((state_reg == ADDR_HI) & hi_match) |
                                   ((state_reg == ADDR_LO) & lo_match));
    assign lo_miss = byte_done & (state_reg == ADDR_LO) & ~lo_match;
    assign data_rx = byte_done & (state_reg == DATA);
    assign store_byte = addr_hit | (data_rx & ~buffer_full_reg);

    // software access decode
    assign wr_buffer = req_i.wr & (req_i.addr == BUFFER_OFS);
    assign rd_buffer = req_i.rd & (req_i.addr == BUFFER_OFS);
    assign wr_ctrl_one = req_i.wr & (req_i.addr == CTRL_ONE_OFS);
    assign wr_address = req_i.wr & (req_i.addr == ADDRESS_OFS);
    assign wr_flag = req_i.wr & (req_i.addr == FLAG_OFS);

    // receive sequencer: start, address bytes, data bytes, stop
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= IDLE;
        end else if (ce_i) begin
            if (!serial_control_one_reg[C1_ENABLE] || stop_det) begin
                state_reg <= IDLE; // port off or transfer ended [RQ12]
            end else if (start_det) begin
                state_reg <= ADDR_HI; // new frame, high address next [RQ13]
            end else if (byte_done) begin
                unique case (state_reg)
                    ADDR_HI: begin
                        state_reg <= hi_match ? ADDR_LO : IGNORE;
                    end
                    ADDR_LO: begin
                        state_reg <= lo_match ? DATA : IGNORE;
                    end
                    DATA: begin
                        state_reg <= DATA; // every byte until stop [RQ12]
                    end
                    IDLE, IGNORE: begin
                        state_reg <= state_reg;
                    end
                endcase
            end
        end
    end

    // bit counter: rises one to eight are data, nine is the ack
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_cnt_reg <= 4'h0;
        end else if (ce_i) begin
            if (start_det || stop_det) begin
                bit_cnt_reg <= 4'h0;
            end else if (scl_rise) begin
                bit_cnt_reg <= (bit_cnt_reg == ACK_BIT) ? 4'h1 : bit_cnt_reg + 4'h1;
            end
        end
    end

    // per-byte bookkeeping taken at the eighth rise
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_pend_reg <= 1'b0;
            event_pend_reg <= 1'b0;
            addr_kind_reg <= 1'b0;
            ua_kind_reg <= 1'b0;
        end else if (ce_i) begin
            if (start_det || stop_det) begin
                ack_pend_reg <= 1'b0;
                event_pend_reg <= 1'b0;
            end else if (byte_done) begin
                ack_pend_reg <= store_byte; // ack only what was taken [RQ2] [RQ6]
                event_pend_reg <= addr_hit | lo_miss | data_rx;
                addr_kind_reg <= state_reg != DATA;
                ua_kind_reg <= addr_hit | lo_miss;
            end else if (ack_fall) begin
                ack_pend_reg <= 1'b0;
                event_pend_reg <= 1'b0;
            end
        end
    end

    // receive buffer: hardware load on a taken byte, else software write
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            serial_buffer_reg <= BUFFER_RST;
        end else if (ce_i) begin
            if (store_byte) begin
                serial_buffer_reg <= rx_byte; // address or data lands here [RQ6]
            end else if (wr_buffer) begin
                serial_buffer_reg <= req_i.wdata;
            end
        end
    end

    // buffer full: set by a taken byte, cleared by a buffer read, set wins
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            buffer_full_reg <= 1'b0;
        end else if (ce_i) begin
            if (store_byte) begin
                buffer_full_reg <= 1'b1; // a missed low byte leaves it alone [RQ7]
            end else if (rd_buffer) begin
                buffer_full_reg <= 1'b0; // [RQ3]
            end
        end
    end

    // update-address bit and the clock hold it causes
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            update_address_reg <= 1'b0;
            ua_hold_reg <= 1'b0;
        end else if (ce_i) begin
            if (addr_hit || lo_miss) begin
                update_address_reg <= 1'b1; // address hit or low-byte miss alike [RQ2] [RQ7]
            end else if (wr_address) begin
                update_address_reg <= 1'b0; // address refreshed [RQ11]
            end
            if (stop_det || start_det) begin
                ua_hold_reg <= 1'b0;
            end else if (ack_fall && ua_kind_reg) begin
                ua_hold_reg <= 1'b1; // hold after the address ack [RQ4]
            end else if (wr_address) begin
                ua_hold_reg <= 1'b0; // address write releases the clock [RQ4] [RQ5]
            end
        end
    end

    // start, stop and data/address status bits
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_seen_reg <= 1'b0;
            stop_seen_reg <= 1'b0;
            data_last_reg <= 1'b0;
        end else if (ce_i) begin
            if (start_det) begin
                start_seen_reg <= 1'b1; // [RQ1]
                stop_seen_reg <= 1'b0;
            end else if (stop_det) begin
                start_seen_reg <= 1'b0;
                stop_seen_reg <= 1'b1;
            end
            if (byte_done) begin
                data_last_reg <= state_reg == DATA;
            end
        end
    end

    // port interrupt flag: hardware sets, writing zero clears, set wins
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_interrupt_flag_reg <= 1'b0;
        end else if (ce_i) begin
            if (start_det && serial_control_three_reg[C3_START_IRQ_EN]) begin
                port_interrupt_flag_reg <= 1'b1; // [RQ1]
            end else if (ack_fall && event_pend_reg) begin
                port_interrupt_flag_reg <= 1'b1; // after the ninth pulse [RQ8] [RQ7]
            end else if (wr_flag && !req_i.wdata[0]) begin
                port_interrupt_flag_reg <= 1'b0;
            end
        end
    end

    // control one: overflow and clock-release bits move in hardware too
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            serial_control_one_reg <= CTRL_ONE_RST;
        end else if (ce_i) begin
            if (wr_ctrl_one) begin
                serial_control_one_reg <= req_i.wdata; // setting release frees [RQ10]
            end else begin
                if (data_rx && buffer_full_reg) begin
                    serial_control_one_reg[C1_OVERFLOW] <= 1'b1; // byte dropped, no ack
                end
                if (data_fall && event_pend_reg &&
                    ((addr_kind_reg && serial_control_three_reg[C3_ADDRESS_HOLD]) ||
                     (!addr_kind_reg && serial_control_three_reg[C3_DATA_HOLD]))) begin
                    serial_control_one_reg[C1_CLOCK_RELEASE] <= 1'b0; // [RQ11]
                end else if (ack_fall && event_pend_reg && !addr_kind_reg &&
                             serial_control_two_reg[C2_STRETCH_ENABLE]) begin
                    serial_control_one_reg[C1_CLOCK_RELEASE] <= 1'b0; // [RQ9]
                end
            end
        end
    end

    // plain software registers
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            serial_control_two_reg <= CTRL_RST;
            serial_control_three_reg <= CTRL_RST;
            address_mask_reg <= MASK_RST;
            slave_address_reg <= ADDRESS_RST;
        end else if (ce_i && req_i.wr) begin
            unique case (req_i.addr)
                CTRL_TWO_OFS: begin
                    serial_control_two_reg <= req_i.wdata;
                end
                CTRL_THREE_OFS: begin
                    serial_control_three_reg <= req_i.wdata;
                end
                MASK_OFS: begin
                    address_mask_reg <= req_i.wdata;
                end
                ADDRESS_OFS: begin
                    slave_address_reg <= req_i.wdata;
                end
                default: begin
                    slave_address_reg <= slave_address_reg; // handled elsewhere
                end
            endcase
        end
    end

    // read data, valid in the cycle after the read strobe
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 8'h00;
        end else if (ce_i && req_i.rd) begin
            unique case (req_i.addr)
                BUFFER_OFS: rdata_reg <= serial_buffer_reg;
                STATUS_OFS: rdata_reg <= {2'b00, data_last_reg, stop_seen_reg,
                                          start_seen_reg, 1'b0, update_address_reg,
                                          buffer_full_reg};
                CTRL_ONE_OFS: rdata_reg <= serial_control_one_reg;
                CTRL_TWO_OFS: rdata_reg <= serial_control_two_reg;
                CTRL_THREE_OFS: rdata_reg <= serial_control_three_reg;
                MASK_OFS: rdata_reg <= address_mask_reg;
                ADDRESS_OFS: rdata_reg <= slave_address_reg;
                FLAG_OFS: rdata_reg <= {7'h00, port_interrupt_flag_reg};
            endcase
        end
    end

    // ack drive: low from the eighth fall to the ninth fall
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sda_oe_reg <= 1'b0;
        end else if (ce_i) begin
            if (start_det || stop_det || ack_fall) begin
                sda_oe_reg <= 1'b0;
            end else if (data_fall && ack_pend_reg) begin
                sda_oe_reg <= 1'b1; // ack clocked out on the ninth pulse [RQ8]
            end
        end
    end

    // clock stretch: pull the clock only once it is already low
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_oe_reg <= 1'b0;
        end else if (ce_i) begin
            if (stop_det || !active) begin
                scl_oe_reg <= 1'b0;
            end else if (ua_hold_reg || !serial_control_one_reg[C1_CLOCK_RELEASE]) begin
                scl_oe_reg <= scl_oe_reg | ~scl_sync_reg[1]; // [RQ4] [RQ9]
            end else begin
                scl_oe_reg <= 1'b0; // released [RQ10]
            end
        end
    end

    // outputs
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_o = scl_oe_reg;
    assign sda_oe_o = sda_oe_reg;
    assign rdata_o = rdata_reg;
    assign port_interrupt_flag_o = port_interrupt_flag_reg;

    // checks
    start_status_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RQ1]
        ce_i && start_det |=> start_seen_reg && (state_reg == ADDR_HI ||
        !serial_control_one_reg[C1_ENABLE]))
        else $error("start not recorded");

    high_addr_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RQ2]
        ce_i && byte_done && state_reg == ADDR_HI && hi_match
        |=> update_address_reg && ack_pend_reg)
        else $error("high address hit not flagged");

    buffer_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RQ3]
        ce_i && rd_buffer && !store_byte |=> !buffer_full_reg)
        else $error("buffer read kept full bit");

    ua_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RQ4]
        ce_i && ua_hold_reg && !wr_address && !start_det && !stop_det |=> ua_hold_reg)
        else $error("clock hold dropped without address write");

    low_match_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RQ6]
        ce_i && byte_done && state_reg == ADDR_LO && lo_match
        |=> buffer_full_reg && serial_buffer_reg == $past(rx_byte) && state_reg == DATA)
        else $error("low address hit not stored");

    low_miss_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RQ7]
        ce_i && lo_miss && !wr_ctrl_one |=> update_address_reg && !ack_pend_reg &&
        $stable(serial_control_one_reg[C1_CLOCK_RELEASE]) && state_reg != DATA)
        else $error("low address miss misbehaved");

    ninth_flag_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RQ8]
        ce_i && ack_fall && event_pend_reg |=> port_interrupt_flag_reg && !sda_oe_reg)
        else $error("flag missing after ack");

    stretch_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RQ9]
        ce_i && ack_fall && event_pend_reg && !addr_kind_reg && !wr_ctrl_one &&
        serial_control_two_reg[C2_STRETCH_ENABLE]
        |=> !serial_control_one_reg[C1_CLOCK_RELEASE])
        else $error("release bit not cleared");

    clock_free_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RQ10]
        ce_i && wr_ctrl_one && req_i.wdata[C1_CLOCK_RELEASE] && !ua_hold_reg
        ##1 ce_i && !ua_hold_reg && active |=> ##1 !scl_oe_reg)
        else $error("clock not released");

endmodule : i2c_slave_ten_bit_addressing

// ===== i2c_master_model.sv
// behavioural bus master: open-drain drive levels, pull-ups give 1 when released
module i2c_master_model (
    // drive levels, 1 = released
    output logic scl_drv_o,
    output logic sda_drv_o,
    // resolved bus levels
    input wire logic scl_i,
    input wire logic sda_i
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle bus: clock stands still high between frames
    initial begin
        scl_drv_o = 1'b1;
        sda_drv_o = 1'b1;
    end

    // release the clock and wait out stretching, bounded so a stuck hold cannot hang
    task automatic raise;
        int n;
        n = 0;
        scl_drv_o = 1'b1;
        while (scl_i !== 1'b1 && n < 4000) begin
            #1 n = n + 1;
        end
    endtask : raise

    // one clock pulse of 64 ns, data sampled mid-high
    task automatic pulse(output logic s);
        #16 raise();
        #16 s = sda_i;
        #16 scl_drv_o = 1'b0;
        #16;
    endtask : pulse

    // start: data falls while the clock is high
    task automatic start;
        sda_drv_o = 1'b1;
        scl_drv_o = 1'b1;
        #40 sda_drv_o = 1'b0;
        #40 scl_drv_o = 1'b0;
        #16;
    endtask : start

    // eight bits msb first, then the ninth pulse carries the ack
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            sda_drv_o = b[i];
            pulse(s);
        end
        sda_drv_o = 1'b1;
        pulse(ack);
    endtask : send_byte

    // stop: data rises while the clock is high, ends the byte cycles
    task automatic stop;
        sda_drv_o = 1'b0;
        #16 raise();
        #40 sda_drv_o = 1'b1;
        #40;
    endtask : stop
endmodule : i2c_master_model

// ===== i2c_slave_ten_bit_addressing_test.sv
module i2c_slave_ten_bit_addressing_test
    import i2c_ten_bit_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;

    // ten-bit address and its two bus bytes; high byte carries the prefix
    localparam logic [9:0] ADDR10 = 10'h2A5;
    localparam logic [7:0] HI_BYTE = {5'b11110, ADDR10[9:8], 1'b0};
    localparam logic [7:0] LO_BYTE = ADDR10[7:0];
    // clock, reset, register port
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    reg_req_t req = '0;
    logic [7:0] rdata;
    logic flag;
    // bus pins and resolved levels
    logic m_scl;
    logic m_sda;
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
    wire scl_line = m_scl & ~(scl_oe & ~scl_o);
    wire sda_line = m_sda & ~(sda_oe & ~sda_o);
    // bookkeeping
    int num_errors = 0;
    int checks_done = 0;
    logic [7:0] rd;
    logic ack;
    logic [7:0] rst_tab [2:6] = '{CTRL_ONE_RST, CTRL_RST, CTRL_RST, MASK_RST, ADDRESS_RST};

    always #5 ref_clk = ~ref_clk;

    i2c_slave_ten_bit_addressing u_i2c_slave_ten_bit_addressing (
        .ref_clk_i(ref_clk), .rst_n_i(rst_n), .ce_i(1'b1), .scl_clk_i(scl_line),
        .scl_i(scl_line), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .req_i(req), .rdata_o(rdata),
        .port_interrupt_flag_o(flag)
    );
    i2c_master_model u_i2c_master_model (
        .scl_drv_o(m_scl), .sda_drv_o(m_sda), .scl_i(scl_line), .sda_i(sda_line)
    );

    // verdict and end of run
    task automatic print_verdict;
        if (num_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one-cycle write strobe
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        req <= '0;
    endtask : reg_wr

    // one-cycle read strobe, data taken in the following cycle
    task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk);
        req <= '0;
        #1 d = rdata;
    endtask : reg_rd

    // bounded wait for the flag, then let the stretch settle
    task automatic wait_flag;
        int n;
        n = 0;
        while (flag !== 1'b1 && n < 40) begin
            @(posedge ref_clk);
            n++;
        end
        check({7'h00, flag}, 8'h01);
        if (n == 40) print_verdict();
        repeat (3) @(posedge ref_clk);
    endtask : wait_flag

    // clock line let go a few cycles after the software write
    task automatic released;
        repeat (3) @(posedge ref_clk);
        check({7'h00, scl_oe}, 8'h00);
    endtask : released

    // acked byte: flag, stretch, status, buffer contents, buffer-full cleared by read
    task automatic rx_byte(input logic [7:0] b, input logic [7:0] st);
        u_i2c_master_model.send_byte(b, ack);
        check({7'h00, ack}, 8'h00);
        wait_flag();
        check({7'h00, scl_oe}, 8'h01);
        reg_rd(STATUS_OFS, rd);
        check(rd & 8'h03, st);
        reg_rd(BUFFER_OFS, rd);
        check(rd, b);
        reg_rd(STATUS_OFS, rd);
        check(rd & 8'h01, 8'h00);
        reg_wr(FLAG_OFS, 8'h00);
    endtask : rx_byte

    // start, flag, high byte acked, low address loaded, clock freed
    task automatic open_frame;
        u_i2c_master_model.start();
        wait_flag();
        reg_rd(STATUS_OFS, rd);
        check(rd & 8'h08, 8'h08);
        reg_wr(FLAG_OFS, 8'h00);
        rx_byte(HI_BYTE, 8'h03);
        reg_wr(ADDRESS_OFS, LO_BYTE);
        released();
    endtask : open_frame

    // hang guard
    initial begin
        #900us;
        num_errors++;
        print_verdict();
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 2; i < 7; i++) begin
            reg_rd(3'(i), rd);
            check(rd, rst_tab[i]);
        end
        reg_wr(CTRL_TWO_OFS, 8'h01);
        reg_wr(CTRL_THREE_OFS, 8'h20);
        reg_wr(ADDRESS_OFS, HI_BYTE);
        reg_wr(CTRL_ONE_OFS, 8'h30);
        open_frame();
        rx_byte(LO_BYTE, 8'h03);
        reg_wr(ADDRESS_OFS, HI_BYTE);
        released();
        // two data bytes, each stretched and freed by software
        for (int i = 0; i < 2; i++) begin
            rx_byte(8'h3C ^ {8{i[0]}}, 8'h01);
            reg_rd(CTRL_ONE_OFS, rd);
            check(rd & 8'h10, 8'h00);
            reg_wr(CTRL_ONE_OFS, 8'h30);
            released();
        end
        u_i2c_master_model.stop();
        // second frame with a low byte that misses
        open_frame();
        u_i2c_master_model.send_byte(~LO_BYTE, ack);
        check({7'h00, ack}, 8'h01);
        wait_flag();
        reg_rd(STATUS_OFS, rd);
        check(rd & 8'h03, 8'h02);
        reg_rd(CTRL_ONE_OFS, rd);
        check(rd & 8'h10, 8'h10);
        reg_wr(ADDRESS_OFS, HI_BYTE);
        released();
        u_i2c_master_model.stop();
        check({7'h00, scl_line}, 8'h01);
        print_verdict();
    end
endmodule : i2c_slave_ten_bit_addressing_test
